// ---- src/ccs_charge_control.sv ----
`timescale 1ns/10ps
// What this block does
// - Start only after both setpoints written nonzero
// - Start only in cold, ideal or underrange
// - Start only while adapter is present
// - Stop when watchdog expires without write pair
// - Stop on overrange or hot range
// - Stop when adapter presence drops
// - Stop while alarm block flag set
// - Inhibit stops; clearing resumes with stored setpoints
// - Clear-setpoints bit stops charging
// - Enable pin low stops; release resumes
// - Low input supply stops; recovery resumes
// - Zero voltage or current write stops
// - Decode every 32 ms with adapter
// - Thresholds tested in fixed descending order
// - Pass ends once range is known
// - Threshold hysteresis from previous range
// - Select switches per threshold pair
// - No adapter: 250 ms samples, 30 s full
// - Standby reports battery presence only
// - Range sets the status flag pattern
// - Current strap picks one of four ceilings
// - Voltage strap picks one of five ceilings
// - Wake-up ends into controlled on write pair
// - Voltage above ceiling clamps and flags
module ccs_charge_control
#(
    parameter longint WDOG_CYCLES = ccs_pkg::WDOG_CYC,   // Watchdog length in cycles
    parameter int     FAST_CYCLES = ccs_pkg::FAST_CYC,   // Decode interval with adapter
    parameter int     SLOW_CYCLES = ccs_pkg::SLOW_CYC,   // Sample interval without adapter
    parameter int     FULL_COUNT  = ccs_pkg::FULL_SLOW_COUNT, // Slow ticks per full pass
    parameter int     SETTLE      = ccs_pkg::SETTLE_CYC  // Settle cycles per step
)
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,                  // Freezes all state when low
    input  wire logic        voltageWrite,           // One-cycle voltage command strobe
    input  wire logic        currentWrite,           // One-cycle current command strobe
    input  wire logic [15:0] writeData,              // Command data for either strobe
    input  wire logic        wakeupActive,           // Wake-up charging running elsewhere
    input  wire logic        flag_alarm_block,       // Alarm block status flag
    input  wire logic        inhibitBit,             // Charge-inhibit mode bit
    input  wire logic        clear_setpoints_bit,    // Clear_setpoints_bit mode bit
    input  wire logic        charge_enable_pin,      // Enable pin level, low means held
    input  wire logic        input_supply,           // Input supply sufficient
    input  wire logic        adapter_divider_input,  // Divider comparator above threshold
    input  wire logic        safety_resistance_input,// Comparator: sense above threshold
    input  wire logic [1:0]  current_limit_strap,    // Current ceiling strap code
    input  wire logic [2:0]  voltage_limit_strap,    // Voltage ceiling strap code
    output logic             chargeOn_r,             // Controlled charging active
    output logic [15:0]      voltageOut_r,           // Clamped voltage setpoint
    output logic [15:0]      currentOut_r,           // Clamped current setpoint
    output logic             flagVoltageOver_r,      // Voltage setpoint was clamped
    output logic             flag_adapter_in_r,      // Adapter present
    output logic             flag_cold_r,            // Range flags
    output logic             flag_ideal_r,
    output logic             flag_hot_r,
    output logic             flag_underrange_r,
    output logic             flag_overrange_r,
    output logic             flagPresent_r,          // Battery present
    output logic             switch_select_a_r,      // Tie pin a to supply
    output logic             switch_select_b_r,      // Tie pin b to supply
    output logic [2:0]       thresholdSel_r,         // Reference select 0..3, top bit always zero
    output logic             thresholdHigh_r         // Hysteresis side of reference
);
    // =====================================================
    // Strap decode
    // =====================================================
    logic [15:0] iMax;          // Current ceiling
    logic [15:0] iMask;         // Current step mask
    logic [15:0] vMax;          // Voltage ceiling
    logic [15:0] vMask;         // Voltage step mask

    ccs_strap_decode uStrap
    (
        .current_limit_strap (current_limit_strap),
        .voltage_limit_strap (voltage_limit_strap),
        .currentMax          (iMax),
        .currentMask         (iMask),
        .voltageMax          (vMax),
        .voltageMask         (vMask)
    );

    // Range to flags: over, cold, ideal, hot, under, present
    function automatic logic [5:0] rangeFlags(input ccs_pkg::ccs_range_t r);
        case (r)
            ccs_pkg::RNG_UNDER: rangeFlags = 6'h19;
            ccs_pkg::RNG_HOT:   rangeFlags = 6'h09;
            ccs_pkg::RNG_IDEAL: rangeFlags = 6'h05;
            ccs_pkg::RNG_COLD:  rangeFlags = 6'h03;
            default:            rangeFlags = 6'h22;
        endcase
    endfunction : rangeFlags

    // Underrange carries hot and present but never overrange

    // =====================================================
    // Setpoints and charging control
    // =====================================================
    logic [15:0] vStore_r, vStore_nxt;       // Last voltage command
    logic [15:0] iStore_r, iStore_nxt;       // Last current command
    logic        vSeen_r, vSeen_nxt;         // Voltage written since last pair
    logic        iSeen_r, iSeen_nxt;         // Current written since last pair
    logic        armed_r, armed_nxt;         // Valid pair held, watchdog running
    logic [47:0] wdog_r, wdog_nxt;           // Watchdog down-counter
    logic        chargeOn_nxt;
    logic [15:0] vOut_nxt, iOut_nxt;
    logic        vOver_nxt;
    logic        adapter_r, adapter_nxt;
    ccs_pkg::ccs_range_t range_r;            // Committed range
    logic        rangeOk;                    // Range allows charging
    logic        holdOff;                    // Resumable pause conditions

    always_comb
    begin
        vStore_nxt  = vStore_r;
        iStore_nxt  = iStore_r;
        vSeen_nxt   = vSeen_r;
        iSeen_nxt   = iSeen_r;
        armed_nxt   = armed_r;
        wdog_nxt    = wdog_r;
        adapter_nxt = adapter_divider_input;
        // Count down while a pair is held
        if (armed_r && wdog_r != 48'h0)
            wdog_nxt = wdog_r - 48'h1;
        if (voltageWrite)
        begin
            vStore_nxt = writeData;
            vSeen_nxt  = 1'b1;
        end
        if (currentWrite)
        begin
            iStore_nxt = writeData;
            iSeen_nxt  = 1'b1;
        end
        // Both written: arm and restart watchdog
        if ((vSeen_nxt && iSeen_nxt) && (vStore_nxt != 16'h0) && (iStore_nxt != 16'h0))
        begin
            armed_nxt = 1'b1;
            wdog_nxt  = WDOG_CYCLES[47:0];
            vSeen_nxt = 1'b0;
            iSeen_nxt = 1'b0;
        end
        // Fatal stops drop the armed state
        if ((voltageWrite && writeData == 16'h0) || (currentWrite && writeData == 16'h0))
            armed_nxt = 1'b0;
        if (clear_setpoints_bit)
        begin
            armed_nxt  = 1'b0;
            vStore_nxt = 16'h0;
            iStore_nxt = 16'h0;
        end
        if (armed_r && wdog_r == 48'h0)
            armed_nxt = 1'b0;
        // Clamp to strap ceilings and step sizes
        vOver_nxt = (vStore_r > vMax);
        vOut_nxt  = (vOver_nxt ? vMax : vStore_r) & vMask;
        iOut_nxt  = ((iStore_r > iMax) ? iMax : iStore_r) & iMask;
        rangeOk   = (range_r == ccs_pkg::RNG_COLD) || (range_r == ccs_pkg::RNG_IDEAL)
                    || (range_r == ccs_pkg::RNG_UNDER);
        holdOff   = inhibitBit || !charge_enable_pin || !input_supply;
        chargeOn_nxt = armed_r && rangeOk && adapter_r
                       && !flag_alarm_block && !holdOff
                       && !clear_setpoints_bit && !wakeupActive;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            vStore_r          <= 16'h0;
            iStore_r          <= 16'h0;
            vSeen_r           <= 1'b0;
            iSeen_r           <= 1'b0;
            armed_r           <= 1'b0;
            wdog_r            <= 48'h0;
            adapter_r         <= 1'b0;
            chargeOn_r        <= 1'b0;
            voltageOut_r      <= 16'h0;
            currentOut_r      <= 16'h0;
            flagVoltageOver_r <= 1'b0;
            flag_adapter_in_r <= 1'b0;
        end
        else if (clkEn)
        begin
            vStore_r          <= vStore_nxt;
            iStore_r          <= iStore_nxt;
            vSeen_r           <= vSeen_nxt;
            iSeen_r           <= iSeen_nxt;
            armed_r           <= armed_nxt;
            wdog_r            <= wdog_nxt;
            adapter_r         <= adapter_nxt;
            chargeOn_r        <= chargeOn_nxt;
            voltageOut_r      <= vOut_nxt;
            currentOut_r      <= iOut_nxt;
            flagVoltageOver_r <= vOver_nxt;
            flag_adapter_in_r <= adapter_nxt;
        end
    end

    // =====================================================
    // Safety resistance decoder sequencer
    // =====================================================
    typedef enum logic [3:0]
    {
        SQ_IDLE   = 4'h1,
        SQ_SETTLE = 4'h2,
        SQ_SAMPLE = 4'h4,
        SQ_COMMIT = 4'h8
    } ccs_seq_t;

    ccs_seq_t            seq_r, seq_nxt;
    logic [31:0]         tick_r, tick_nxt;       // Interval counter
    logic [15:0]         slowCnt_r, slowCnt_nxt; // Slow ticks since last full pass
    logic [7:0]          settle_r, settle_nxt;   // Settle counter
    logic [1:0]          step_r, step_nxt;       // Threshold index 0..3
    logic                fullPass_r, fullPass_nxt; // Full pass versus presence probe
    ccs_pkg::ccs_range_t found_r, found_nxt;     // Range under construction
    ccs_pkg::ccs_range_t range_nxt;
    logic [5:0]          flags_r, flags_nxt;
    logic                selA_nxt, selB_nxt, thrHigh_nxt;
    logic [2:0]          thrSel_nxt;

    // Range that lies above threshold index i
    function automatic ccs_pkg::ccs_range_t aboveOf(input logic [1:0] i);
        case (i)
            2'h0:    aboveOf = ccs_pkg::RNG_OVER;
            2'h1:    aboveOf = ccs_pkg::RNG_COLD;
            2'h2:    aboveOf = ccs_pkg::RNG_IDEAL;
            default: aboveOf = ccs_pkg::RNG_HOT;
        endcase
    endfunction : aboveOf

    always_comb
    begin
        seq_nxt      = seq_r;
        tick_nxt     = tick_r + 32'h1;
        slowCnt_nxt  = slowCnt_r;
        settle_nxt   = settle_r;
        step_nxt     = step_r;
        fullPass_nxt = fullPass_r;
        found_nxt    = found_r;
        range_nxt    = range_r;
        flags_nxt    = flags_r;
        selA_nxt     = 1'b0;
        selB_nxt     = 1'b0;
        thrSel_nxt   = {1'b0, step_r};
        // Hysteresis: boundary of prior range leans toward keeping it
        thrHigh_nxt  = (range_r == aboveOf(step_r));
        case (seq_r)
            SQ_IDLE:
            begin
                if (adapter_r && tick_r >= FAST_CYCLES - 1)
                begin
                    tick_nxt     = 32'h0;
                    fullPass_nxt = 1'b1;
                    seq_nxt      = SQ_SETTLE;
                end
                else if (!adapter_r && tick_r >= SLOW_CYCLES - 1)
                begin
                    tick_nxt     = 32'h0;
                    // Presence probe only, full pass every thirty seconds
                    fullPass_nxt = (slowCnt_r >= FULL_COUNT[15:0] - 16'h1);
                    slowCnt_nxt  = fullPass_nxt ? 16'h0 : slowCnt_r + 16'h1;
                    seq_nxt      = SQ_SETTLE;
                end
                step_nxt   = 2'h0;
                settle_nxt = 8'h0;
            end
            SQ_SETTLE:
            begin
                // Upper pair reads a with b tied; lower pair the reverse
                selB_nxt   = !step_r[1];
                selA_nxt   = step_r[1];
                settle_nxt = settle_r + 8'h1;
                if (settle_r >= SETTLE[7:0] - 8'h1)
                    seq_nxt = SQ_SAMPLE;
            end
            SQ_SAMPLE:
            begin
                selB_nxt   = !step_r[1];
                selA_nxt   = step_r[1];
                settle_nxt = 8'h0;
                if (safety_resistance_input)
                begin
                    found_nxt = aboveOf(step_r);
                    seq_nxt   = SQ_COMMIT;
                end
                else if (step_r == 2'h3)
                begin
                    found_nxt = ccs_pkg::RNG_UNDER;
                    seq_nxt   = SQ_COMMIT;
                end
                else if (!fullPass_r)
                begin
                    // Probe: below overrange means present
                    found_nxt = (range_r == ccs_pkg::RNG_OVER) ? ccs_pkg::RNG_IDEAL : range_r;
                    seq_nxt   = SQ_COMMIT;
                end
                else
                begin
                    step_nxt = step_r + 2'h1;
                    seq_nxt  = SQ_SETTLE;
                end
            end
            SQ_COMMIT:
            begin
                range_nxt = found_r;
                flags_nxt = rangeFlags(found_r);
                seq_nxt   = SQ_IDLE;
            end
            default:
                seq_nxt = SQ_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            seq_r             <= SQ_IDLE;
            tick_r            <= 32'h0;
            slowCnt_r         <= 16'h0;
            settle_r          <= 8'h0;
            step_r            <= 2'h0;
            fullPass_r        <= 1'b0;
            found_r           <= ccs_pkg::RANGE_RESET;
            range_r           <= ccs_pkg::RANGE_RESET;
            flags_r           <= 6'h22;
            switch_select_a_r <= 1'b0;
            switch_select_b_r <= 1'b0;
            thresholdSel_r    <= 3'h0;
            thresholdHigh_r   <= 1'b0;
        end
        else if (clkEn)
        begin
            seq_r             <= seq_nxt;
            tick_r            <= tick_nxt;
            slowCnt_r         <= slowCnt_nxt;
            settle_r          <= settle_nxt;
            step_r            <= step_nxt;
            fullPass_r        <= fullPass_nxt;
            found_r           <= found_nxt;
            range_r           <= range_nxt;
            flags_r           <= flags_nxt;
            switch_select_a_r <= selA_nxt;
            switch_select_b_r <= selB_nxt;
            thresholdSel_r    <= thrSel_nxt;
            thresholdHigh_r   <= thrHigh_nxt;
        end
    end

    // Flags layout: [5] over, [4] under, [3] hot, [2] ideal, [1] cold, [0] present
    assign flag_overrange_r  = flags_r[5];
    assign flag_underrange_r = flags_r[4];
    assign flag_hot_r        = flags_r[3];
    assign flag_ideal_r      = flags_r[2];
    assign flag_cold_r       = flags_r[1];
    assign flagPresent_r     = flags_r[0];
endmodule : ccs_charge_control

// ---- src/ccs_pkg.sv ----
package ccs_pkg;
    // =====================================================
    // Timing
    // =====================================================
    localparam int CLK_HZ          = 50_000_000;   // System clock rate
    localparam int FAST_PERIOD_MS  = 32;           // Decode interval with adapter
    localparam int SLOW_PERIOD_MS  = 250;          // Presence sample interval without adapter
    localparam int FULL_PERIOD_S   = 30;           // Full decode interval without adapter
    localparam int WDOG_PERIOD_MS  = 175000;       // Command watchdog period, ms
    localparam int FAST_CYC        = CLK_HZ / 1000 * FAST_PERIOD_MS;
    localparam int SLOW_CYC        = CLK_HZ / 1000 * SLOW_PERIOD_MS;
    localparam int FULL_SLOW_COUNT = FULL_PERIOD_S * 1000 / SLOW_PERIOD_MS; // Slow ticks per full pass
    localparam int SETTLE_CYC      = 16;           // Comparator settle cycles per step
    localparam longint WDOG_CYC    = longint'(CLK_HZ) / 1000 * WDOG_PERIOD_MS;

    // =====================================================
    // Safety range (one-hot)
    // =====================================================
    typedef enum logic [4:0]
    {
        RNG_OVER  = 5'h01,
        RNG_COLD  = 5'h02,
        RNG_IDEAL = 5'h04,
        RNG_HOT   = 5'h08,
        RNG_UNDER = 5'h10
    } ccs_range_t;
    localparam ccs_range_t RANGE_RESET = RNG_OVER;  // Assume no battery at reset

    // =====================================================
    // Strap codes and limits
    // =====================================================
    localparam logic [15:0] CURRENT_LIMIT_STRAP_0 = 16'h03FF;  // 1023 mA
    localparam logic [15:0] CURRENT_LIMIT_STRAP_1 = 16'h07FE;  // 2046 mA
    localparam logic [15:0] CURRENT_LIMIT_STRAP_2 = 16'h0BFC;  // 3068 mA
    localparam logic [15:0] CURRENT_LIMIT_STRAP_3 = 16'h0FFC;  // 4092 mA
    localparam logic [15:0] IMASK_0 = 16'hFFFF; // 1 mA steps
    localparam logic [15:0] IMASK_1 = 16'hFFFE; // 2 mA steps
    localparam logic [15:0] IMASK_2 = 16'hFFFC; // 4 mA steps
    localparam logic [15:0] VOLTAGE_LIMIT_STRAP_0 = 16'h1090;  // 4240 mV
    localparam logic [15:0] VOLTAGE_LIMIT_STRAP_1 = 16'h10D0;  // 4304 mV
    localparam logic [15:0] VOLTAGE_LIMIT_STRAP_2 = 16'h1150;  // 4432 mV
    localparam logic [15:0] VOLTAGE_LIMIT_STRAP_3 = 16'h11A0;  // 4512 mV
    localparam logic [15:0] VOLTAGE_LIMIT_STRAP_4 = 16'h1580;  // 5504 mV
    localparam logic [15:0] VMASK  = 16'hFFF0;  // 16 mV steps
endpackage : ccs_pkg

// ---- src/ccs_strap_decode.sv ----
`timescale 1ns/10ps
// =====================================================
// Strap decoders for current and voltage ceilings
// =====================================================
module ccs_strap_decode
(
    input  wire logic [1:0]  current_limit_strap,   // Four-level strap code
    input  wire logic [2:0]  voltage_limit_strap,   // Five-level strap code
    output logic      [15:0] currentMax,            // Ceiling in mA
    output logic      [15:0] currentMask,           // Granularity mask
    output logic      [15:0] voltageMax,            // Ceiling in mV
    output logic      [15:0] voltageMask            // Granularity mask
);
    // Current ceiling per strap, not software-alterable
    always_comb
    begin
        case (current_limit_strap)
            2'h0:    begin currentMax = ccs_pkg::CURRENT_LIMIT_STRAP_0; currentMask = ccs_pkg::IMASK_0; end
            2'h1:    begin currentMax = ccs_pkg::CURRENT_LIMIT_STRAP_1; currentMask = ccs_pkg::IMASK_1; end
            2'h2:    begin currentMax = ccs_pkg::CURRENT_LIMIT_STRAP_2; currentMask = ccs_pkg::IMASK_2; end
            default: begin currentMax = ccs_pkg::CURRENT_LIMIT_STRAP_3; currentMask = ccs_pkg::IMASK_2; end
        endcase
    end

    // Voltage ceiling per strap; codes above four read as open
    always_comb
    begin
        voltageMask = ccs_pkg::VMASK;
        case (voltage_limit_strap)
            3'h0:    voltageMax = ccs_pkg::VOLTAGE_LIMIT_STRAP_0;
            3'h1:    voltageMax = ccs_pkg::VOLTAGE_LIMIT_STRAP_1;
            3'h2:    voltageMax = ccs_pkg::VOLTAGE_LIMIT_STRAP_2;
            3'h3:    voltageMax = ccs_pkg::VOLTAGE_LIMIT_STRAP_3;
            default: voltageMax = ccs_pkg::VOLTAGE_LIMIT_STRAP_4;
        endcase
    end
endmodule : ccs_strap_decode

// ---- tb/ccs_battery_model.sv ----
`timescale 1ns/10ps
// ==========================================
// Battery sense network: range 0 over .. 4 under
module ccs_battery_model
(
    input  wire logic       clk,
    input  wire logic       switch_select_a_r,
    input  wire logic       switch_select_b_r,
    input  wire logic [2:0] thresholdSel_r,
    input  wire logic [2:0] rangeIdx,
    output logic            senseHigh
);
    // Valid only with the proper pin tied, otherwise a toggling level
    assign senseHigh = (thresholdSel_r[1] ? switch_select_a_r : switch_select_b_r)
        ? (rangeIdx <= {1'b0, thresholdSel_r[1:0]}) : clk;
endmodule : ccs_battery_model

// ---- tb/ccs_charge_control_sva.sv ----
`timescale 1ns/10ps
// ==========================================
// Checker on the charge control ports
module ccs_charge_control_sva
(
    input wire logic       clk, rst_n, clkEn, flag_alarm_block, inhibitBit, clear_setpoints_bit,
    input wire logic       charge_enable_pin, input_supply, wakeupActive, adapter_divider_input,
    input wire logic       chargeOn_r, flag_overrange_r, flag_cold_r, flag_hot_r, flag_underrange_r,
    input wire logic       flagPresent_r, switch_select_a_r, switch_select_b_r,
    input wire logic [2:0] thresholdSel_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Adapter loss passes the input register first
    sequence s_noAdp; clkEn && !adapter_divider_input ##1 clkEn; endsequence
    property p_alarm; clkEn && flag_alarm_block |=> !chargeOn_r; endproperty
    a_alarm: assert property (p_alarm) else $error("charge on under alarm block");
    property p_inhibit; clkEn && inhibitBit |=> !chargeOn_r; endproperty
    a_inhibit: assert property (p_inhibit) else $error("charge on while inhibited");
    property p_clear; clkEn && clear_setpoints_bit |=> !chargeOn_r; endproperty
    a_clear: assert property (p_clear) else $error("charge on with clear bit");
    property p_pin; clkEn && !charge_enable_pin |=> !chargeOn_r; endproperty
    a_pin: assert property (p_pin) else $error("charge on with enable pin held");
    property p_supply; clkEn && !input_supply |=> !chargeOn_r; endproperty
    a_supply: assert property (p_supply) else $error("charge on with low supply");
    property p_wake; clkEn && wakeupActive |=> !chargeOn_r; endproperty
    a_wake: assert property (p_wake) else $error("charge on during wake-up");
    property p_range;
        clkEn && (flag_overrange_r || (flag_hot_r && !flag_underrange_r)) |=> !chargeOn_r;
    endproperty
    a_range: assert property (p_range) else $error("charge on in hot or overrange");
    property p_adp; s_noAdp |=> !chargeOn_r; endproperty
    a_adp: assert property (p_adp) else $error("charge on without adapter");
    property p_fOver; flag_overrange_r |-> flag_cold_r && !flagPresent_r && !flag_hot_r; endproperty
    a_fOver: assert property (p_fOver) else $error("overrange flag pattern wrong");
    property p_fUnder; flag_underrange_r |-> flag_hot_r && flagPresent_r && !flag_cold_r; endproperty
    a_fUnder: assert property (p_fUnder) else $error("underrange flag pattern wrong");
    property p_sel;
        (switch_select_a_r || switch_select_b_r) |->
            (switch_select_a_r == thresholdSel_r[1]) && (switch_select_a_r != switch_select_b_r);
    endproperty
    a_sel: assert property (p_sel) else $error("wrong sense pin tied");
endmodule : ccs_charge_control_sva

bind ccs_charge_control ccs_charge_control_sva u_sva (.clk, .rst_n, .clkEn, .flag_alarm_block, .inhibitBit,
    .clear_setpoints_bit, .charge_enable_pin, .input_supply, .wakeupActive, .adapter_divider_input, .chargeOn_r,
    .flag_overrange_r, .flag_cold_r, .flag_hot_r, .flag_underrange_r, .flagPresent_r, .switch_select_a_r,
    .switch_select_b_r, .thresholdSel_r);

// ---- tb/ccs_charge_control_tb_top.sv ----
`timescale 1ns/10ps
// ==========================================
// Bench for charge control
module ccs_charge_control_tb_top;
    logic clk = 0, rst_n = 0, clkEn = 1, vWr = 0, cWr = 0, clr = 0, adp = 0, sense, on, vOver;
    logic fOv, fCo, fId, fHo, fUn, fPr, selA, selB, adIn, thHi, alarm, inh, pin, sup, wake;
    logic [15:0] wd = 16'h0000, vOut, cOut, v, c, vM, iM;
    logic [4:0]  p = 5'h00;
    logic [2:0]  vS, thSel, rng = 3'h2;
    logic [1:0]  iS;
    int mismatches = 0, samples_checked = 0, seed = 65137, i, k;
    localparam logic [4:0] FL [5] = '{5'h18, 5'h09, 5'h01, 5'h05, 5'h07};
    localparam logic [15:0] VL [5] = '{ccs_pkg::VOLTAGE_LIMIT_STRAP_0, ccs_pkg::VOLTAGE_LIMIT_STRAP_1, ccs_pkg::VOLTAGE_LIMIT_STRAP_2, ccs_pkg::VOLTAGE_LIMIT_STRAP_3,
        ccs_pkg::VOLTAGE_LIMIT_STRAP_4};
    localparam logic [15:0] IL [4] = '{ccs_pkg::CURRENT_LIMIT_STRAP_0, ccs_pkg::CURRENT_LIMIT_STRAP_1, ccs_pkg::CURRENT_LIMIT_STRAP_2, ccs_pkg::CURRENT_LIMIT_STRAP_3};
    localparam logic [15:0] IK [4] = '{ccs_pkg::IMASK_0, ccs_pkg::IMASK_1, ccs_pkg::IMASK_2, ccs_pkg::IMASK_2};
    localparam logic [2:0] ORD [5] = '{3'h2, 3'h3, 3'h1, 3'h0, 3'h4};
    // Pause causes, one bit each
    assign alarm = p[0];
    assign inh = p[1];
    assign pin = !p[2];
    assign sup = !p[3];
    assign wake = p[4];
    always #10 clk = ~clk;
    ccs_charge_control #(.WDOG_CYCLES(200), .FAST_CYCLES(100), .SLOW_CYCLES(100), .FULL_COUNT(4), .SETTLE(4)) dut
    (.clk, .rst_n, .clkEn, .voltageWrite(vWr), .currentWrite(cWr), .writeData(wd), .wakeupActive(wake),
     .flag_alarm_block(alarm), .inhibitBit(inh), .clear_setpoints_bit(clr), .charge_enable_pin(pin),
     .input_supply(sup), .adapter_divider_input(adp), .safety_resistance_input(sense), .current_limit_strap(iS),
     .voltage_limit_strap(vS), .chargeOn_r(on), .voltageOut_r(vOut), .currentOut_r(cOut), .flagVoltageOver_r(vOver),
     .flag_adapter_in_r(adIn), .flag_cold_r(fCo), .flag_ideal_r(fId), .flag_hot_r(fHo), .flag_underrange_r(fUn),
     .flag_overrange_r(fOv), .flagPresent_r(fPr), .switch_select_a_r(selA), .switch_select_b_r(selB),
     .thresholdSel_r(thSel), .thresholdHigh_r(thHi));
    ccs_battery_model u_bat (.clk, .switch_select_a_r(selA), .switch_select_b_r(selB), .thresholdSel_r(thSel),
        .rangeIdx(rng), .senseHigh(sense));
    // ==========================================
    // Helpers
    task summarize;
        if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin mismatches++; $display("mismatch at %0t: got %h want %h", $time, seen, exp); end
    endtask : chk
    task tick(input int n); repeat (n) @(negedge clk); endtask : tick
    task wr(input logic [15:0] vv, input logic [15:0] cc);
        @(negedge clk) begin vWr = 1; wd = vv; end
        @(negedge clk) begin vWr = 0; cWr = 1; wd = cc; end
        @(negedge clk) cWr = 0;
        tick(3);
    endtask : wr
    // ==========================================
    // Main sequence
    initial
    begin
        vS = 3'($unsigned($random(seed)) % 5);
        iS = 2'($random(seed));
        v = 16'h1000 + (16'($random(seed)) & 16'h07F0);
        c = 16'h0100 + (16'($random(seed)) & 16'h0FF0);
        vM = (v > VL[vS]) ? VL[vS] : v;
        iM = ((c & IK[iS]) > IL[iS]) ? IL[iS] : (c & IK[iS]);
        tick(12);
        rst_n = 1;
        chk({fOv, fCo, fHo, fUn, fPr}, FL[0]);
        adp = 1;
        @(negedge clk) begin vWr = 1; wd = v; end
        @(negedge clk) vWr = 0;
        tick(3);
        chk(on, 0);
        for (i = 0; i < 5; i++)
        begin
            rng = ORD[i];
            for (k = 0; k < 400 && {fOv, fCo, fHo, fUn, fPr} !== FL[rng]; k++) tick(1);
            if (k == 400) begin mismatches++; summarize(); end
            chk({fOv, fCo, fHo, fUn, fPr}, FL[rng]);
            chk(fId, rng == 2);
            wr(v, c);
            chk(on, rng != 0 && rng != 3);
        end
        chk(vOut, vM);
        chk(vOver, v > VL[vS]);
        chk(cOut, iM);
        for (i = 0; i < 5; i++)
        begin
            p = 5'h01 << i;
            tick(2);
            chk(on, 0);
            p = 5'h00;
            tick(3);
            chk(on, 1);
        end
        wr(v, c);
        tick(187);
        chk(on, 1);
        tick(15);
        chk(on, 0);
        for (i = 0; i < 2; i++)
        begin
            wr(v, c);
            chk(on, 1);
            wr(i ? v : 16'h0000, i ? 16'h0000 : c);
            chk(on, 0);
        end
        wr(v, c);
        clr = 1;
        tick(2);
        chk(on, 0);
        clr = 0;
        tick(3);
        chk(on, 0);
        chk(vOut, 16'h0000);
        wr(v, c);
        adp = 0;
        tick(3);
        chk(on, 0);
        chk(adIn, 0);
        wr(v, c);
        chk(on, 0);
        summarize();
    end
endmodule : ccs_charge_control_tb_top
